/* File: hdl/embls_top.sv */
// Top of the external memory byte-lane steering block.
// Assumes one clock; internal requester holds request until o_done.
`timescale 1ns/10ps
`include "embls_defs.svh"
module embls_top (
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_rst_b, // Async reset, active low
   input wire logic i_clk_en, // Freezes all state when low
   input wire logic i_req, // Access request level
   input wire logic i_write, // 1 write, 0 read
   input wire logic [1:0] i_dtype, // Operand data type
   input wire logic i_use_ptr, // 1 pointer address, 0 direct
   input wire logic [`EMBLS_PTR_SEL_W-1:0] i_ptr_sel, // 0 program counter, 1..22 general regs
   input wire logic [`EMBLS_BYTE_ADDR_W-1:0] i_direct_addr, // Direct address from instruction
   input wire logic [`EMBLS_BYTE_ADDR_W-1:0] i_program_counter, // Program counter value
   input wire logic [`EMBLS_PTR_REGS*`EMBLS_BYTE_ADDR_W-1:0] i_general_pointer_regs, // Slices 0..22 packed
   input wire logic [`EMBLS_DATA_W-1:0] i_wr_data, // Operand, right aligned
   input wire logic [`EMBLS_DATA_W-1:0] i_ext_data_bus, // External data bus in
   output logic [`EMBLS_WORD_ADDR_W-1:0] o_ext_word_addr, // External word address
   output logic [`EMBLS_LANES-1:0] o_byte_lane_sel_n, // Lane selects, active low
   output logic [`EMBLS_DATA_W-1:0] o_ext_data_bus, // External data bus out
   output logic o_ext_data_oe, // Data bus drive enable
   output logic o_ext_write_n, // Write strobe, active low
   output logic [`EMBLS_DATA_W-1:0] o_rd_data, // Read operand, right aligned
   output logic o_done // One-cycle completion pulse
);
   // ****************************************
   // Input sync of external data bus
   // ****************************************
   logic [`EMBLS_DATA_W-1:0] bus_meta_q; // First stage, read only by second
   logic [`EMBLS_DATA_W-1:0] bus_sync_q; // Second stage
   // Two flops since memory data is asynchronous to our clock
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bus_meta_q <= '0;
         bus_sync_q <= '0;
      end else if (i_clk_en) begin
         bus_meta_q <= i_ext_data_bus;
         bus_sync_q <= bus_meta_q;
      end
   end

   // ****************************************
   // Address source selection
   // ****************************************
   logic [`EMBLS_BYTE_ADDR_W-1:0] ptr_val [`EMBLS_PTR_REGS]; // Unpacked pointer view
   logic [`EMBLS_BYTE_ADDR_W-1:0] byte_addr; // Selected byte address
   genvar gi;
   generate
      for (gi = 0; gi < `EMBLS_PTR_REGS; gi++) begin : g_ptr
         assign ptr_val[gi] = i_general_pointer_regs[gi*`EMBLS_BYTE_ADDR_W +: `EMBLS_BYTE_ADDR_W];
      end
   endgenerate
   // Out-of-range pointer select falls back to the direct address
   always_comb begin
      byte_addr = i_direct_addr;
      if (i_use_ptr) begin
         if (i_ptr_sel == `EMBLS_SRC_PC) begin
            byte_addr = i_program_counter;
         end else if (i_ptr_sel < 5'(`EMBLS_PTR_REGS)) begin
            byte_addr = ptr_val[i_ptr_sel];
         end
      end
   end

   // ****************************************
   // Lane decode and write steering
   // ****************************************
   logic [`EMBLS_LANES-1:0] sel_n; // Decoded selects
   logic [`EMBLS_DATA_W-1:0] wr_steer; // Steered write data
   embls_lane_decode u_dec (
      .i_low_addr(byte_addr[1:0]),
      .i_dtype(i_dtype),
      .o_sel_n(sel_n)
   );
   // Byte and halfword copies let memory pick its lane without a shifter
   always_comb begin
      wr_steer = i_wr_data;
      case (i_dtype)
         `EMBLS_TYPE_BYTE: begin
            wr_steer = {4{i_wr_data[7:0]}};
         end
         `EMBLS_TYPE_HALF: begin
            wr_steer = {2{i_wr_data[15:0]}};
         end
         `EMBLS_TYPE_INT24: begin
            wr_steer = {{8{i_wr_data[23]}}, i_wr_data[23:0]};
         end
         default: begin
            wr_steer = i_wr_data;
         end
      endcase
   end

   // ****************************************
   // Bus cycle control
   // ****************************************
   embls_pkg::embls_state_t state_q, state_d; // Phase
   logic [`EMBLS_WORD_ADDR_W-1:0] addr_q, addr_d; // Word address
   logic [`EMBLS_LANES-1:0] sel_q, sel_d; // Lane selects
   logic [`EMBLS_DATA_W-1:0] dout_q, dout_d; // Bus out data
   logic oe_q, oe_d; // Drive enable
   logic wr_n_q, wr_n_d; // Write strobe
   logic [`EMBLS_DATA_W-1:0] rd_q, rd_d; // Read operand
   logic done_q, done_d; // Completion pulse
   logic [1:0] wait_q, wait_d; // Read settle count for sync delay
   logic [1:0] rtype_q, rtype_d; // Latched type for read extract
   logic [1:0] rlow_q, rlow_d; // Latched low address bits
   // Next-state logic; two idle cycles between accesses
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      sel_d = sel_q;
      dout_d = dout_q;
      oe_d = oe_q;
      wr_n_d = 1'b1;
      rd_d = rd_q;
      done_d = 1'b0;
      wait_d = wait_q;
      rtype_d = rtype_q;
      rlow_d = rlow_q;
      case (state_q)
         embls_pkg::EMBLS_IDLE: begin
            sel_d = `EMBLS_SEL_IDLE;
            oe_d = 1'b0;
            if (i_req && !done_q) begin
               addr_d = byte_addr[`EMBLS_BYTE_ADDR_W-1:2];
               sel_d = sel_n;
               rtype_d = i_dtype;
               rlow_d = byte_addr[1:0];
               if (i_write) begin
                  dout_d = wr_steer;
                  oe_d = 1'b1;
                  wr_n_d = 1'b0;
                  state_d = embls_pkg::EMBLS_WRITE;
               end else begin
                  wait_d = `EMBLS_RD_WAIT;
                  state_d = embls_pkg::EMBLS_READ;
               end
            end
         end
         embls_pkg::EMBLS_WRITE: begin
            // Drive enable and selects drop with the strobe; no data hold cycle
            sel_d = `EMBLS_SEL_IDLE;
            oe_d = 1'b0;
            done_d = 1'b1;
            state_d = embls_pkg::EMBLS_IDLE;
         end
         embls_pkg::EMBLS_READ: begin
            if (wait_q != 2'h0) begin
               wait_d = wait_q - 2'h1;
            end else begin
               case (rtype_q)
                  `EMBLS_TYPE_BYTE: begin
                     rd_d = {24'h0, bus_sync_q[8*rlow_q +: 8]};
                  end
                  `EMBLS_TYPE_HALF: begin
                     rd_d = {16'h0, rlow_q[1] ? bus_sync_q[31:16] : bus_sync_q[15:0]};
                  end
                  `EMBLS_TYPE_INT24: begin
                     rd_d = {{8{bus_sync_q[23]}}, bus_sync_q[23:0]};
                  end
                  default: begin
                     rd_d = bus_sync_q;
                  end
               endcase
               sel_d = `EMBLS_SEL_IDLE;
               done_d = 1'b1;
               state_d = embls_pkg::EMBLS_IDLE;
            end
         end
         default: begin
            state_d = embls_pkg::EMBLS_IDLE;
         end
      endcase
   end
   // Registers only; clock enable freezes all
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= embls_pkg::EMBLS_IDLE;
         addr_q <= '0;
         sel_q <= `EMBLS_SEL_IDLE;
         dout_q <= '0;
         oe_q <= 1'b0;
         wr_n_q <= 1'b1;
         rd_q <= '0;
         done_q <= 1'b0;
         wait_q <= 2'h0;
         rtype_q <= 2'h0;
         rlow_q <= 2'h0;
      end else if (i_clk_en) begin
         state_q <= state_d;
         addr_q <= addr_d;
         sel_q <= sel_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
         wr_n_q <= wr_n_d;
         rd_q <= rd_d;
         done_q <= done_d;
         wait_q <= wait_d;
         rtype_q <= rtype_d;
         rlow_q <= rlow_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_ext_word_addr = addr_q;
   assign o_byte_lane_sel_n = sel_q;
   assign o_ext_data_bus = dout_q;
   assign o_ext_data_oe = oe_q;
   assign o_ext_write_n = wr_n_q;
   assign o_rd_data = rd_q;
   assign o_done = done_q;
endmodule

/* File: hdl/embls_defs.svh */
// Constants for the external memory byte-lane steering block.
// Assumes inclusion by bare name from hdl/ sources.
`ifndef EMBLS_DEFS_SVH
`define EMBLS_DEFS_SVH
// ****************************************
// Widths
// ****************************************
`define EMBLS_BYTE_ADDR_W 24
`define EMBLS_WORD_ADDR_W 22
`define EMBLS_DATA_W 32
`define EMBLS_LANES 4
`define EMBLS_PTR_REGS 23
`define EMBLS_PTR_SEL_W 5
// ****************************************
// Data type codes and source selection
// ****************************************
`define EMBLS_TYPE_BYTE 2'h0
`define EMBLS_TYPE_HALF 2'h1
`define EMBLS_TYPE_INT24 2'h2
`define EMBLS_TYPE_WORD 2'h3
`define EMBLS_SRC_PC 5'h00
// ****************************************
// Reset values
// ****************************************
`define EMBLS_SEL_IDLE 4'hF
// ****************************************
// Timing counts
// ****************************************
// Extra read cycles that cover the two-flop data bus sync
`define EMBLS_RD_WAIT 2'h2
`endif

/* File: hdl/embls_pkg.sv */
// Types for the external memory byte-lane steering block.
// Assumes embls_defs.svh is reachable on the include path.
`include "embls_defs.svh"
package embls_pkg;
   // Operand data type of an access
   typedef enum logic [1:0] {
      EMBLS_BYTE_T_VAL = `EMBLS_TYPE_BYTE,
      EMBLS_HALF_T_VAL = `EMBLS_TYPE_HALF,
      EMBLS_INT24_T_VAL = `EMBLS_TYPE_INT24,
      EMBLS_WORD_T_VAL = `EMBLS_TYPE_WORD
   } embls_dtype_t;
   // Bus cycle phase
   typedef enum logic [1:0] {
      EMBLS_IDLE,
      EMBLS_WRITE,
      EMBLS_READ
   } embls_state_t;
endpackage

/* File: hdl/embls_lane_decode.sv */
// Lane select decoder: low address bits and data type to lane selects.
// Assumes purely combinational use inside the steering top.
`timescale 1ns/10ps
`include "embls_defs.svh"
module embls_lane_decode (
   input wire logic [1:0] i_low_addr, // Two low byte-address bits
   input wire logic [1:0] i_dtype, // Operand data type code
   output logic [`EMBLS_LANES-1:0] o_sel_n // Active-low lane selects
);
   // ****************************************
   // Decode
   // ****************************************
   // Byte: inverted one-hot lane mask; halfword and wider: active-low constants
   always_comb begin
      o_sel_n = `EMBLS_SEL_IDLE;
      case (i_dtype)
         `EMBLS_TYPE_BYTE: begin
            o_sel_n = ~(4'h1 << i_low_addr);
         end
         `EMBLS_TYPE_HALF: begin
            o_sel_n = i_low_addr[1] ? 4'h3 : 4'hC;
         end
         default: begin
            o_sel_n = 4'h0;
         end
      endcase
   end
endmodule

/* File: bench/embls_mem_model.sv */
// Behavioural static memory on the 32-bit external bus.
// Assumes the steering top drives word address, lane selects and strobe.
`timescale 1ns/10ps
module embls_mem_model (
   input wire logic i_clock, // Clock
   input wire logic [21:0] i_word_addr, // Word address
   input wire logic [3:0] i_sel_n, // Lane selects
   input wire logic [31:0] i_wdata, // Write data
   input wire logic i_write_n, // Write strobe
   output logic [31:0] o_rdata // Read data
);
   // ****************
   // Word store
   // ****************
   logic [31:0] mem [0:15]; // Small, address folds
   logic [7:0] churn = 8'h00; // Changes every cycle
   always @(posedge i_clock) begin
      churn <= churn + 8'h3B;
      for (int k = 0; k < 4; k++) begin
         if (!i_write_n && !i_sel_n[k]) begin
            mem[i_word_addr[3:0]][k*8 +: 8] <= i_wdata[k*8 +: 8];
         end
      end
   end
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         o_rdata[k*8 +: 8] = i_sel_n[k] ? churn ^ 8'(k) : mem[i_word_addr[3:0]][k*8 +: 8];
      end
   end
endmodule

/* File: bench/embls_top_assertions.sv */
// Checker of lane selects, word address and write steering.
// Assumes bind onto embls_top and requests held until done.
`timescale 1ns/10ps
module embls_chk (
   input wire logic i_clock, // Clock
   input wire logic i_rst_b, // Reset, active low
   input wire logic i_clk_en, // Clock enable
   input wire logic i_req, // Request
   input wire logic i_write, // Write
   input wire logic [1:0] i_dtype, // Data type
   input wire logic i_use_ptr, // Pointer use
   input wire logic [4:0] i_ptr_sel, // Pointer select
   input wire logic [23:0] i_direct_addr, // Direct address
   input wire logic [23:0] i_program_counter, // Program counter
   input wire logic [551:0] i_general_pointer_regs, // Pointers
   input wire logic [31:0] i_wr_data, // Operand
   input wire logic [21:0] o_ext_word_addr, // Word address
   input wire logic [3:0] o_byte_lane_sel_n, // Lane selects
   input wire logic [31:0] o_ext_data_bus, // Bus out
   input wire logic o_ext_data_oe, // Bus drive enable
   input wire logic o_ext_write_n, // Write strobe
   input wire logic o_done // Done
);
   // ****************
   // Helpers
   // ****************
   logic [23:0] addr; // Expected byte address
   logic act; // Some lane selected
   logic wr; // Write strobe low
   // Address source; selects above 22 fall back to direct
   always_comb begin
      addr = i_direct_addr;
      if (i_use_ptr && i_ptr_sel == 5'h00) begin
         addr = i_program_counter;
      end else if (i_use_ptr && i_ptr_sel < 5'h17) begin
         addr = i_general_pointer_regs[i_ptr_sel*24 +: 24];
      end
   end
   assign act = o_byte_lane_sel_n != 4'hF;
   assign wr = !o_ext_write_n;
   default clocking @(posedge i_clock); endclocking
   // A frozen clock stretches every bus cycle, so all checks but freeze_hold_a are disabled while frozen
   default disable iff (!i_rst_b || !i_clk_en);
   word_addr_a: assert property (act |-> o_ext_word_addr == addr[23:2])
      else $error("word address wrong");
   byte_lane_a: assert property (act && i_dtype == 2'h0 |-> o_byte_lane_sel_n == ~(4'h1 << addr[1:0]))
      else $error("byte lane select wrong");
   half_lane_a: assert property (act && i_dtype == 2'h1 |-> o_byte_lane_sel_n == (addr[1] ? 4'h3 : 4'hC))
      else $error("halfword lane select wrong");
   full_lane_a: assert property (act && i_dtype[1] |-> o_byte_lane_sel_n == 4'h0)
      else $error("full lane select wrong");
   wdata_byte_a: assert property (wr && i_dtype == 2'h0 |-> o_ext_data_bus == {4{i_wr_data[7:0]}})
      else $error("byte write data wrong");
   wdata_half_a: assert property (wr && i_dtype == 2'h1 |-> o_ext_data_bus == {2{i_wr_data[15:0]}})
      else $error("halfword write data wrong");
   wdata_int24_a: assert property (wr && i_dtype == 2'h2 |-> o_ext_data_bus == {{8{i_wr_data[23]}}, i_wr_data[23:0]})
      else $error("int24 write data wrong");
   wdata_word_a: assert property (wr && i_dtype == 2'h3 |-> o_ext_data_bus == i_wr_data)
      else $error("word write data wrong");
   write_time_a: assert property ($rose(i_req) && i_write |-> ##1 (wr && act) ##1 (o_done && !act))
      else $error("write timing wrong");
   read_time_a: assert property ($rose(i_req) && !i_write |-> ##1 (act && !wr && !o_done)[*3] ##1 (o_done && !act))
      else $error("read timing wrong");
   // bus driven only in the write cycle
   oe_write_a: assert property (o_ext_data_oe == wr)
      else $error("data drive enable wrong");
   freeze_hold_a: assert property (disable iff (!i_rst_b) !i_clk_en |=>
      $stable(o_byte_lane_sel_n) && $stable(o_ext_word_addr) && $stable(o_done))
      else $error("outputs moved while frozen");
   wr_c: cover property (wr && i_dtype == 2'h2);
   rd_c: cover property (o_done && !i_write && i_use_ptr);
   half_c: cover property (act && i_dtype == 2'h1 && addr[1]);
endmodule
bind embls_top embls_chk embls_chk_i (.i_clock, .i_rst_b, .i_clk_en, .i_req, .i_write, .i_dtype, .i_use_ptr,
   .i_ptr_sel, .i_direct_addr, .i_program_counter, .i_general_pointer_regs, .i_wr_data, .o_ext_word_addr,
   .o_byte_lane_sel_n, .o_ext_data_bus, .o_ext_data_oe, .o_ext_write_n, .o_done);

/* File: bench/embls_top_tb.sv */
// Self-checking bench of the steering top with a memory model.
// Assumes the model answers combinationally on selected lanes.
`timescale 1ns/10ps
module embls_top_tb;
   logic i_clock = 1'b0, i_rst_b = 1'b0, i_clk_en = 1'b1, i_req = 1'b0, i_write = 1'b0, i_use_ptr = 1'b0;
   logic [1:0] i_dtype = 2'h0;
   logic [4:0] i_ptr_sel = 5'h00;
   logic [23:0] i_direct_addr = 24'h000000, i_program_counter = 24'h000000;
   logic [551:0] i_general_pointer_regs = '0;
   logic [31:0] i_wr_data = 32'h00000000, i_ext_data_bus, o_ext_data_bus, o_rd_data;
   logic [21:0] o_ext_word_addr;
   logic [3:0] o_byte_lane_sel_n;
   logic o_ext_data_oe, o_ext_write_n, o_done;
   int errors = 0, n_tests = 0;
   embls_top embls_top_i (.i_clock, .i_rst_b, .i_clk_en, .i_req, .i_write, .i_dtype, .i_use_ptr,
      .i_ptr_sel, .i_direct_addr, .i_program_counter, .i_general_pointer_regs, .i_wr_data, .i_ext_data_bus,
      .o_ext_word_addr, .o_byte_lane_sel_n, .o_ext_data_bus, .o_ext_data_oe, .o_ext_write_n, .o_rd_data, .o_done);
   embls_mem_model embls_mem_model_i (.i_clock, .i_word_addr(o_ext_word_addr), .i_sel_n(o_byte_lane_sel_n),
      .i_wdata(o_ext_data_bus), .i_write_n(o_ext_write_n), .o_rdata(i_ext_data_bus));
   // Free-running 200 MHz clock
   initial begin
      forever #2.5 i_clock = ~i_clock;
   end
   task automatic conclude();
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         $display("wrong value %s expected %h seen %h", nm, ex, got);
         errors++;
      end
   endtask
   // One whole access; held until done, bounded wait
   task automatic run(input logic w, input logic [1:0] dt, input logic up, input logic [4:0] ps,
      input logic [23:0] a, input logic [31:0] wd, input logic [31:0] ex);
      int n = 0;
      @(posedge i_clock);
      #1;
      {i_req, i_write, i_dtype, i_use_ptr, i_ptr_sel, i_direct_addr, i_wr_data} = {1'b1, w, dt, up, ps, a, wd};
      while (o_done !== 1'b1 && n < 20) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (n == 20) begin
         errors++;
         conclude();
      end
      i_req = 1'b0;
      if (!w) chk("read data", ex, o_rd_data);
   endtask
   task automatic t_reset();
      chk("idle outputs", 32'h0000001F, {o_ext_data_oe, o_done, o_byte_lane_sel_n, o_ext_write_n});
   endtask
   task automatic t_bytes();
      run(1'b1, 2'h3, 1'b0, 5'h00, 24'h000010, 32'hA5B6C7D8, 32'h0);
      run(1'b1, 2'h0, 1'b0, 5'h00, 24'h000011, 32'hFFFFFF5E, 32'h0);
      run(1'b0, 2'h0, 1'b0, 5'h00, 24'h000011, 32'h0, 32'h0000005E);
      run(1'b0, 2'h1, 1'b0, 5'h00, 24'h000013, 32'h0, 32'h0000A5B6);
      for (int k = 0; k < 4; k++) begin
         run(1'b1, 2'h0, 1'b0, 5'h00, 24'h000030 + 24'(k), 32'h10 + 32'(k), 32'h0);
      end
      run(1'b0, 2'h3, 1'b0, 5'h00, 24'h000030, 32'h0, 32'h13121110);
   endtask
   task automatic t_half_int24();
      run(1'b1, 2'h1, 1'b0, 5'h00, 24'h000010, 32'h12348001, 32'h0);
      run(1'b0, 2'h2, 1'b0, 5'h00, 24'h000010, 32'h0, 32'hFFB68001);
      run(1'b0, 2'h3, 1'b0, 5'h00, 24'h000012, 32'h0, 32'hA5B68001);
   endtask
   task automatic t_pointers();
      i_general_pointer_regs[22*24 +: 24] = 24'h000020;
      i_program_counter = 24'h000020;
      run(1'b1, 2'h2, 1'b1, 5'h16, 24'h000000, 32'h77123456, 32'h0);
      run(1'b0, 2'h3, 1'b1, 5'h00, 24'h000000, 32'h0, 32'h00123456);
      run(1'b0, 2'h0, 1'b1, 5'h17, 24'h000022, 32'h0, 32'h00000012);
   endtask
   // Word read frozen just after it is taken; selects must hold, data still right
   task automatic t_freeze();
      int n = 0;
      @(posedge i_clock);
      #1;
      {i_req, i_write, i_dtype, i_use_ptr, i_direct_addr} = {1'b1, 1'b0, 2'h3, 1'b0, 24'h000030};
      @(posedge i_clock);
      #1;
      i_clk_en = 1'b0;
      repeat (4) @(posedge i_clock);
      #1;
      chk("frozen selects", 32'h00000000, {27'h0, o_done, o_byte_lane_sel_n});
      i_clk_en = 1'b1;
      while (o_done !== 1'b1 && n < 20) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (n == 20) begin
         errors++;
         conclude();
      end
      i_req = 1'b0;
      chk("read after freeze", 32'h13121110, o_rd_data);
   endtask
   // Reset for six cycles, then the scenarios
   initial begin
      repeat (6) @(posedge i_clock);
      #1;
      i_rst_b = 1'b1;
      t_reset();
      t_bytes();
      t_half_int24();
      t_pointers();
      t_freeze();
      conclude();
   end
endmodule
